// file: src/isa_glue_pkg.sv
// Purpose: Constants for the ISA glue block: decodes, irq steering, power hold.
// Assumes: One 50 MHz clock, synchronous active-high reset.
// Notes: Pin inputs pass two flops; rules listed below.
// Function
// - Pull ready low in EPP to lengthen cycle
// - Disk enable only when enabled and addressed
// - First disk select covers eight command addresses
// - Second disk select hits alternate status location
// - Never select disk for 377 or 3F7
// - Each irq line carries chosen source
// - External irq routable to any line A-H
// - Shared mode pulses irq low then releases
// - General decode over 1, 8 or 16 bytes
// - Joystick select on base match, AEN low
// - Power invalid: ignore inputs, float outputs
// - Registers kept while power invalid
// - Ring indicate and serial irq always live
// - Second drive status shown in floppy status A; code shows it in PS/2 mode only, else 0
// - Ring bit inverted; rising edge sets flag
package isa_glue_pkg;
    localparam int ADDR_W = 10;
    localparam int IRQ_LINES = 8;
    localparam int SRC_W = 4;
    localparam int NUM_DEV = 15;
    // Source code 0 = none, 1..14 internal devices, 15 = external input
    localparam logic [SRC_W-1:0] SRC_NONE = 4'h0;
    localparam logic [SRC_W-1:0] SRC_EXT = 4'hf;
    localparam logic [ADDR_W-1:0] DISK_EXCL_A = 10'h377;
    localparam logic [ADDR_W-1:0] DISK_EXCL_B = 10'h3f7;
    localparam logic [ADDR_W-1:0] DISK_ALT_OFS = 10'h006;
    localparam int CMD_BLOCK_LSB = 3;
    localparam int BLK16_LSB = 4;
    localparam int BLK8_LSB = 3;
    localparam logic [1:0] BLK_SIZE_1 = 2'h0;
    localparam logic [1:0] BLK_SIZE_8 = 2'h1;
    localparam logic [1:0] BLK_SIZE_16 = 2'h2;
    localparam int SRA_SECOND_DRIVE_PRESENT_BIT = 6;
    localparam int MSR_RI_BIT = 6;
    localparam int MSR_TERI_BIT = 2;
    localparam real REF_CLK_MHZ = 14.318;
    localparam real MCLK_MHZ = 50.0;
    // One reference period in 20 ns cycles, rounded up, at least one
    localparam int REF_PERIOD_CYC = int'($ceil(MCLK_MHZ / REF_CLK_MHZ));
    localparam int PULSE_CNT_W = 3;
    typedef enum logic [1:0] {
        IRQ_IDLE = 2'b00,
        IRQ_PULSE = 2'b01,
        IRQ_WAIT = 2'b10
    } irq_state_type;
endpackage : isa_glue_pkg

// file: src/irq_line.sv
// Purpose: One interrupt output line, level or shared pulse mode.
// Assumes: Request is synchronous to i_mclk.
// Notes: Pulse mode drives low one reference period, then floats.
`timescale 1ns/1ps
`default_nettype none
module irq_line (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_req,
    input wire logic i_shared,
    input wire logic i_enable,
    output logic o_irq,
    output logic o_irq_oe
);
    isa_glue_pkg::irq_state_type state_reg, state_next;
    logic [isa_glue_pkg::PULSE_CNT_W-1:0] cnt_reg, cnt_next;
    logic req_d_reg;
    wire req_rise = i_req & ~req_d_reg;
    wire cnt_done = (cnt_reg == isa_glue_pkg::PULSE_CNT_W'(isa_glue_pkg::REF_PERIOD_CYC - 1));

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            isa_glue_pkg::IRQ_IDLE: begin
                cnt_next = '0;
                if (req_rise) begin
                    state_next = isa_glue_pkg::IRQ_PULSE;
                end
            end
            isa_glue_pkg::IRQ_PULSE: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_done) begin
                    state_next = isa_glue_pkg::IRQ_WAIT;
                end
            end
            isa_glue_pkg::IRQ_WAIT: begin
                cnt_next = '0;
                if (!i_req) begin
                    state_next = isa_glue_pkg::IRQ_IDLE;
                end
            end
            default: begin
                state_next = isa_glue_pkg::IRQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            state_reg <= isa_glue_pkg::IRQ_IDLE;
            cnt_reg <= '0;
            req_d_reg <= 1'b0;
        end else begin
            state_reg <= i_shared ? state_next : isa_glue_pkg::IRQ_IDLE;
            cnt_reg <= i_shared ? cnt_next : '0;
            req_d_reg <= i_req;
        end
    end

    // Shared: low pulse then release; level: driven high with request
    assign o_irq = i_shared ? 1'b0 : i_req;
    assign o_irq_oe = i_enable & (i_shared ? (state_reg == isa_glue_pkg::IRQ_PULSE) : 1'b1);
endmodule : irq_line
`default_nettype wire

// file: src/isa_select_irq_steering.sv
// Purpose: ISA glue: disk, joystick, general decodes, irq steering, ready, power hold.
// Assumes: Address, AEN and pins synchronised here; config ports static-ish.
// Notes: Tristate pins appear as value plus output enable.
`timescale 1ns/1ps
`default_nettype none
module isa_select_irq_steering (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic [9:0] i_sa,
    input wire logic i_aen,
    input wire logic i_power_valid,
    input wire logic i_epp_mode,
    input wire logic i_ecp_mode,
    input wire logic i_epp_wait,
    input wire logic i_disk_if_enable,
    input wire logic [9:0] i_disk_cmd_base,
    input wire logic [9:0] i_disk_alt_base,
    input wire logic [9:0] i_joystick_base_config,
    input wire logic [9:0] i_general_base,
    input wire logic [1:0] i_general_size,
    input wire logic [14:1] i_dev_irq,
    input wire logic i_external_irq_input,
    input wire logic [31:0] i_irq_source_cfg,
    input wire logic i_second_drive_present,
    input wire logic i_floppy_mode_ps2,
    input wire logic i_ring_indicate_n,
    input wire logic i_serial_irq,
    input wire logic i_msr_read,
    output logic o_iochrdy,
    output logic o_iochrdy_oe,
    output logic o_disk_if_select_n,
    output logic o_disk_cmd_block_select_n,
    output logic o_disk_alt_status_select_n,
    output logic o_general_decode_select_n,
    output logic o_joystick_select_n,
    output logic o_select_oe,
    output logic [7:0] o_irq,
    output logic [7:0] o_irq_oe,
    output logic o_serial_irq,
    output logic o_msr_ring_bit,
    output logic o_msr_ring_edge,
    output logic o_floppy_status_a_second_drive_present,
    output logic o_low_power
);
    // Two-flop synchronisers for pin inputs
    logic [9:0] sa_s1_reg, sa_s2_reg;
    logic aen_s1_reg, aen_s2_reg;
    logic pv_s1_reg, pv_s2_reg;
    logic ext_s1_reg, ext_s2_reg;
    logic drv_s1_reg, drv_s2_reg;
    logic ri_s1_reg, ri_s2_reg;
    logic ri_d_reg;
    logic ring_edge_reg, ring_edge_next;
    logic second_drive_present_reg;
    logic [9:0] sa_hold_reg;
    logic aen_hold_reg;
    logic ext_hold_reg;
    logic [14:1] dev_hold_reg;

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            sa_s1_reg <= '0;
            sa_s2_reg <= '0;
            aen_s1_reg <= 1'b1;
            aen_s2_reg <= 1'b1;
            pv_s1_reg <= 1'b0;
            pv_s2_reg <= 1'b0;
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            drv_s1_reg <= 1'b1;
            drv_s2_reg <= 1'b1;
            ri_s1_reg <= 1'b1;
            ri_s2_reg <= 1'b1;
        end else begin
            sa_s1_reg <= i_sa;
            sa_s2_reg <= sa_s1_reg;
            aen_s1_reg <= i_aen;
            aen_s2_reg <= aen_s1_reg;
            pv_s1_reg <= i_power_valid;
            pv_s2_reg <= pv_s1_reg;
            ext_s1_reg <= i_external_irq_input;
            ext_s2_reg <= ext_s1_reg;
            drv_s1_reg <= i_second_drive_present;
            drv_s2_reg <= drv_s1_reg;
            ri_s1_reg <= i_ring_indicate_n;
            ri_s2_reg <= ri_s1_reg;
        end
    end

    wire powered = pv_s2_reg;

    // Inputs frozen while power invalid; held state retained
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            sa_hold_reg <= '0;
            aen_hold_reg <= 1'b1;
            ext_hold_reg <= 1'b0;
            dev_hold_reg <= '0;
            second_drive_present_reg <= 1'b1;
        end else if (powered) begin
            sa_hold_reg <= sa_s2_reg;
            aen_hold_reg <= aen_s2_reg;
            ext_hold_reg <= ext_s2_reg;
            dev_hold_reg <= i_dev_irq;
            second_drive_present_reg <= drv_s2_reg;
        end
    end

    // Decode
    function automatic logic match_above(input logic [9:0] a, input logic [9:0] b,
                                         input int lsb);
        logic [9:0] mask;
        mask = 10'h3ff << lsb;
        match_above = ((a & mask) == (b & mask));
    endfunction : match_above

    wire addr_ok = ~aen_hold_reg;
    wire excluded = (sa_hold_reg == isa_glue_pkg::DISK_EXCL_A) |
                    (sa_hold_reg == isa_glue_pkg::DISK_EXCL_B);
    wire cmd_hit = match_above(sa_hold_reg, i_disk_cmd_base,
                               isa_glue_pkg::CMD_BLOCK_LSB);
    wire alt_hit = (sa_hold_reg == (i_disk_alt_base + isa_glue_pkg::DISK_ALT_OFS));
    wire disk_ok = addr_ok & i_disk_if_enable & ~excluded;
    wire cmd_sel = disk_ok & cmd_hit;
    wire alt_sel = disk_ok & alt_hit;
    wire gen_hit = (i_general_size == isa_glue_pkg::BLK_SIZE_16) ?
                       match_above(sa_hold_reg, i_general_base, isa_glue_pkg::BLK16_LSB) :
                   (i_general_size == isa_glue_pkg::BLK_SIZE_8) ?
                       match_above(sa_hold_reg, i_general_base, isa_glue_pkg::BLK8_LSB) :
                       (sa_hold_reg == i_general_base);
    wire joy_hit = (sa_hold_reg == i_joystick_base_config);

    assign o_disk_cmd_block_select_n = ~cmd_sel;
    assign o_disk_alt_status_select_n = ~alt_sel;
    assign o_disk_if_select_n = ~(cmd_sel | alt_sel);
    assign o_general_decode_select_n = ~(addr_ok & gen_hit);
    assign o_joystick_select_n = ~(addr_ok & joy_hit);
    assign o_select_oe = powered;

    // Ready stretch, open drain
    assign o_iochrdy = 1'b0;
    assign o_iochrdy_oe = powered & i_epp_mode & i_epp_wait;

    // Irq steering
    wire shared = i_epp_mode | i_ecp_mode;
    wire [15:0] src_vec = {ext_hold_reg, dev_hold_reg, 1'b0};

    genvar g;
    generate
        for (g = 0; g < isa_glue_pkg::IRQ_LINES; g++) begin : g_irq
            wire [3:0] sel = i_irq_source_cfg[g*4 +: 4];
            wire req = src_vec[sel];
            irq_line u_line (
                .i_mclk(i_mclk),
                .i_sys_rst(i_sys_rst),
                .i_req(req),
                .i_shared(shared),
                .i_enable(powered & (sel != isa_glue_pkg::SRC_NONE)),
                .o_irq(o_irq[g]),
                .o_irq_oe(o_irq_oe[g])
            );
        end
    endgenerate

    // Ring indicate and serial irq stay live regardless of power valid
    assign o_serial_irq = i_serial_irq;
    assign ring_edge_next = (ri_s2_reg & ~ri_d_reg) | (ring_edge_reg & ~i_msr_read);

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            ri_d_reg <= 1'b1;
            ring_edge_reg <= 1'b0;
            o_msr_ring_bit <= 1'b0;
            o_floppy_status_a_second_drive_present <= 1'b1;
        end else begin
            ri_d_reg <= ri_s2_reg;
            ring_edge_reg <= ring_edge_next;
            o_msr_ring_bit <= ~ri_s2_reg;
            o_floppy_status_a_second_drive_present <= i_floppy_mode_ps2 ? second_drive_present_reg : 1'b0;
        end
    end
    assign o_msr_ring_edge = ring_edge_reg;
    assign o_low_power = ~powered;
endmodule : isa_select_irq_steering
`default_nettype wire

// file: tb/isa_glue_asserts.sv
// Purpose: Port assertions for the ISA glue block.
// Assumes: A pin change reaches the selects three edges later.
// Notes: Bound from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module isa_glue_asserts (
    input wire logic i_mclk, input wire logic i_sys_rst, input wire logic [9:0] i_sa,
    input wire logic i_aen, input wire logic i_power_valid, input wire logic i_epp_mode,
    input wire logic i_ecp_mode, input wire logic i_epp_wait, input wire logic i_disk_if_enable,
    input wire logic [9:0] i_disk_cmd_base, input wire logic [9:0] i_joystick_base_config,
    input wire logic i_ring_indicate_n, input wire logic o_iochrdy_oe,
    input wire logic o_disk_if_select_n, input wire logic o_disk_cmd_block_select_n,
    input wire logic o_disk_alt_status_select_n, input wire logic o_joystick_select_n,
    input wire logic o_select_oe, input wire logic [7:0] o_irq_oe,
    input wire logic o_msr_ring_bit, input wire logic o_low_power
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    wire excl = i_sa == 10'h377 || i_sa == 10'h3f7;
    wire live = !i_aen && i_power_valid;
    chk_ready_stretch: assert property (
        o_iochrdy_oe == (i_epp_mode && i_epp_wait && !o_low_power)) else $error("ready wrong");
    chk_aen_quiet: assert property (
        (i_aen && i_power_valid) [*4] |-> o_disk_if_select_n && o_disk_cmd_block_select_n
        && o_disk_alt_status_select_n && o_joystick_select_n) else $error("select under AEN");
    chk_excluded_addr: assert property (
        (excl && i_power_valid) [*4] |-> o_disk_if_select_n && o_disk_cmd_block_select_n
        && o_disk_alt_status_select_n) else $error("disk select on excluded address");
    chk_cmd_block: assert property (
        (live && i_disk_if_enable && !excl && i_sa[9:3] == i_disk_cmd_base[9:3]) [*4]
        |-> !o_disk_cmd_block_select_n) else $error("command block not selected");
    chk_disk_gate: assert property (
        !o_disk_if_select_n |-> i_disk_if_enable) else $error("disk select while disabled");
    chk_joy_match: assert property (
        (live && i_sa == i_joystick_base_config) [*4] |-> !o_joystick_select_n)
        else $error("joystick not selected");
    chk_power_float: assert property (
        o_low_power |-> !o_select_oe && o_irq_oe == 8'h00 && !o_iochrdy_oe)
        else $error("output driven in low power");
    chk_shared_pulse: assert property (
        (i_epp_mode || i_ecp_mode) && $rose(o_irq_oe[0]) |-> o_irq_oe[0] [*4] ##1 !o_irq_oe[0])
        else $error("shared pulse width wrong");
    chk_ring_level: assert property (
        i_ring_indicate_n [*4] |-> !o_msr_ring_bit) else $error("ring bit not inverted");
    chk_ring_low: assert property (
        (!i_ring_indicate_n) [*4] |-> o_msr_ring_bit) else $error("ring bit not set");
endmodule : isa_glue_asserts
`default_nettype wire

// file: tb/isa_host_model.sv
// Purpose: Host side of the ISA bus: address and AEN.
// Assumes: Changes on falling edges only.
// Notes: A released bus shows the inverted address.
`timescale 1ns/1ps
`default_nettype none
module isa_host_model (
    input wire logic i_mclk,
    output logic [9:0] o_sa,
    output logic o_aen
);
    initial begin
        o_sa = 10'h000;
        o_aen = 1'b1;
    end
    task automatic io_cycle(input logic [9:0] addr, input logic aen, input int hold);
        @(negedge i_mclk);
        o_sa = addr;
        o_aen = aen;
        repeat (hold) @(negedge i_mclk);
    endtask : io_cycle
    task automatic release_bus();
        @(negedge i_mclk);
        o_sa = ~o_sa;
        o_aen = 1'b1;
    endtask : release_bus
endmodule : isa_host_model
`default_nettype wire

// file: tb/isa_select_irq_steering_tb.sv
// Purpose: Self-checking bench for the ISA glue block.
// Assumes: Inputs change on falling edges.
// Notes: Decode table first, then hand-written cases.
`timescale 1ns/1ps
`default_nettype none
module isa_select_irq_steering_tb;
    logic i_mclk, i_sys_rst = 1'b1, i_power_valid = 1'b1, i_epp_mode = 1'b0, i_ecp_mode = 1'b0;
    logic i_epp_wait = 1'b0, i_disk_if_enable = 1'b1, i_external_irq_input = 1'b0;
    logic i_second_drive_present = 1'b1, i_floppy_mode_ps2 = 1'b0, i_ring_indicate_n = 1'b1;
    logic i_serial_irq = 1'b0, i_msr_read = 1'b0;
    logic [1:0] i_general_size = 2'h1;
    logic [14:1] i_dev_irq = 14'h0;
    logic [31:0] i_irq_source_cfg = 32'h0;
    logic [9:0] i_disk_cmd_base = 10'h370, i_disk_alt_base = 10'h3f0;
    logic [9:0] i_joystick_base_config = 10'h201, i_general_base = 10'h300;
    wire [9:0] i_sa;
    wire [7:0] o_irq, o_irq_oe;
    wire i_aen, o_iochrdy, o_iochrdy_oe, o_disk_if_select_n, o_disk_cmd_block_select_n;
    wire o_disk_alt_status_select_n, o_general_decode_select_n, o_joystick_select_n;
    wire o_select_oe, o_serial_irq, o_msr_ring_bit, o_msr_ring_edge, o_floppy_status_a_second_drive_present;
    wire o_low_power;
    wire [7:0] sel = {3'h0, o_disk_if_select_n, o_disk_cmd_block_select_n,
        o_disk_alt_status_select_n, o_general_decode_select_n, o_joystick_select_n};
    wire [7:0] ring_view = {5'h0, o_msr_ring_bit, o_msr_ring_edge, o_floppy_status_a_second_drive_present};
    wire [7:0] power_view = {4'h0, o_select_oe, o_low_power, o_serial_irq, o_irq_oe[0]};
    int num_errors, checked, n;
    // Address, AEN, expected {if, cmd, alt, general, joystick}
    logic [15:0] rows [11] = '{{10'h370, 1'b0, 5'h07}, {10'h376, 1'b0, 5'h07},
        {10'h377, 1'b0, 5'h1f}, {10'h3f6, 1'b0, 5'h0b}, {10'h3f7, 1'b0, 5'h1f},
        {10'h201, 1'b0, 5'h1e}, {10'h300, 1'b0, 5'h1d}, {10'h307, 1'b0, 5'h1d},
        {10'h308, 1'b0, 5'h1f}, {10'h370, 1'b1, 5'h1f}, {10'h201, 1'b1, 5'h1f}};
    isa_host_model isa_host_model_i (.i_mclk, .o_sa(i_sa), .o_aen(i_aen));
    isa_select_irq_steering isa_select_irq_steering_i (.i_mclk, .i_sys_rst, .i_sa, .i_aen,
        .i_power_valid, .i_epp_mode, .i_ecp_mode, .i_epp_wait, .i_disk_if_enable,
        .i_disk_cmd_base, .i_disk_alt_base, .i_joystick_base_config, .i_general_base,
        .i_general_size, .i_dev_irq, .i_external_irq_input, .i_irq_source_cfg,
        .i_second_drive_present, .i_floppy_mode_ps2, .i_ring_indicate_n, .i_serial_irq,
        .i_msr_read, .o_iochrdy, .o_iochrdy_oe, .o_disk_if_select_n, .o_disk_cmd_block_select_n,
        .o_disk_alt_status_select_n, .o_general_decode_select_n, .o_joystick_select_n,
        .o_select_oe, .o_irq, .o_irq_oe, .o_serial_irq, .o_msr_ring_bit, .o_msr_ring_edge,
        .o_floppy_status_a_second_drive_present, .o_low_power);
    initial begin
        i_mclk = 1'b0;
        // Single clock source for all block timing
        forever #10 i_mclk = ~i_mclk;
    end
    task automatic cyc(input int k);
        repeat (k) @(negedge i_mclk);
    endtask : cyc
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    initial begin
        repeat (2000) @(posedge i_mclk);
        num_errors++;
        stop_test();
    end
    initial begin
        cyc(12);
        chk("reset", {6'h0, o_low_power, o_select_oe}, 8'h02);
        i_sys_rst = 1'b0;
        cyc(4);
        foreach (rows[r]) begin
            isa_host_model_i.io_cycle(rows[r][15:6], rows[r][5], 4);
            chk("selects", sel, {3'h0, rows[r][4:0]});
        end
        $display("done decode table");
        i_general_size = isa_glue_pkg::BLK_SIZE_16;
        isa_host_model_i.io_cycle(10'h30f, 1'b0, 4);
        chk("block 16", sel, 8'h1d);
        i_general_size = isa_glue_pkg::BLK_SIZE_1;
        isa_host_model_i.io_cycle(10'h301, 1'b0, 4);
        chk("block 1", sel, 8'h1f);
        isa_host_model_i.io_cycle(10'h300, 1'b0, 4);
        chk("block 1 hit", sel, 8'h1d);
        isa_host_model_i.release_bus();
        i_disk_if_enable = 1'b0;
        isa_host_model_i.io_cycle(10'h370, 1'b0, 4);
        chk("disk off", sel, 8'h1f);
        i_disk_if_enable = 1'b1;
        i_external_irq_input = 1'b1;
        for (int k = 0; k < 8; k++) begin
            i_irq_source_cfg = (32'(isa_glue_pkg::SRC_EXT) << 4 * k) |
                (32'(k + 1) << 4 * ((k + 1) % 8));
            i_dev_irq = 14'h1 << k;
            cyc(4);
            chk("irq lines", o_irq, (8'h01 << k) | (8'h01 << (k + 1) % 8));
        end
        i_external_irq_input = 1'b0;
        i_dev_irq = 14'h0;
        i_irq_source_cfg = 32'h1;
        i_ecp_mode = 1'b1;
        cyc(4);
        i_dev_irq = 14'h1;
        n = 0;
        repeat (10) begin
            cyc(1);
            n += o_irq_oe[0] && !o_irq[0];
        end
        chk("pulse", 8'(n), 8'h04);
        i_epp_mode = 1'b1;
        i_epp_wait = 1'b1;
        cyc(1);
        chk("ready", {6'h0, o_iochrdy, o_iochrdy_oe}, 8'h01);
        i_epp_wait = 1'b0;
        i_ring_indicate_n = 1'b0;
        i_second_drive_present = 1'b0;
        i_floppy_mode_ps2 = 1'b1;
        i_msr_read = 1'b1;
        cyc(1);
        chk("ready", {6'h0, o_iochrdy, o_iochrdy_oe}, 8'h00);
        i_msr_read = 1'b0;
        cyc(4);
        chk("ring", ring_view, 8'h04);
        i_ring_indicate_n = 1'b1;
        i_serial_irq = 1'b1;
        cyc(4);
        chk("ring", ring_view, 8'h02);
        i_power_valid = 1'b0;
        cyc(4);
        i_ring_indicate_n = 1'b0;
        i_second_drive_present = 1'b1;
        cyc(4);
        chk("off", power_view, 8'h06);
        chk("held", ring_view, 8'h06);
        i_power_valid = 1'b1;
        cyc(4);
        chk("kept", ring_view, 8'h07);
        i_msr_read = 1'b1;
        cyc(1);
        i_msr_read = 1'b0;
        chk("cleared", ring_view, 8'h05);
        $display("done hand tests");
        stop_test();
    end
endmodule : isa_select_irq_steering_tb
bind isa_select_irq_steering isa_glue_asserts isa_glue_asserts_i (.i_mclk, .i_sys_rst, .i_sa,
    .i_aen, .i_power_valid, .i_epp_mode, .i_ecp_mode, .i_epp_wait, .i_disk_if_enable,
    .i_disk_cmd_base, .i_joystick_base_config, .i_ring_indicate_n, .o_iochrdy_oe,
    .o_disk_if_select_n, .o_disk_cmd_block_select_n, .o_disk_alt_status_select_n,
    .o_joystick_select_n, .o_select_oe, .o_irq_oe, .o_msr_ring_bit, .o_low_power);
`default_nettype wire
